// File: src/opi_defs.svh
`ifndef OPI_DEFS_SVH
`define OPI_DEFS_SVH

// register numbers on the serial bus
`define OPI_REG_LSW      8'h00
`define OPI_REG_MSW      8'h01
`define OPI_REG_RANGE    8'h02

// field layout
`define OPI_MSW_W        10
`define OPI_OE_BIT       10
`define OPI_RANGE_W      4
`define OPI_PULL_W       26

// serial framing
`define OPI_ACK_SLOT     4'h8
`define OPI_LAST_BIT     4'h7
`define OPI_DIR_WRITE    1'b1

// frequency change timing, typical figures
`define OPI_MCLK_NS      10
`define OPI_FDELAY_NS    22000
`define OPI_SETTLE_NS    30000
`define OPI_CNT_W        12

`endif

// File: src/opi_pkg.sv
package opi_pkg;
	// protocol states of the slave engine
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_REG,
		ST_WR,
		ST_RD
	} opi_state_e;

	typedef logic [15:0] opi_word_t;
	typedef logic [25:0] opi_pull_t;
	typedef logic [18:0] opi_span_t;
endpackage

// File: src/opi_slave.sv
`timescale 1ns/1ps
`include "opi_defs.svh"
// Overview of operation
// - Pull-range register bits 15..4 read zero; writes to them are dropped.
// - Pull-range field resets to a factory value and is writable afterwards.
// - Pull-range code maps to sixteen rising spans, 6.25 to 3200 ppm.
// - Slave only: serial clock is never driven; fine up to 1 MHz.
// - Data line is stable while clock is high; changes once per low phase.
// - Start and stop conditions frame every transaction and are detected.
// - Repeated start restarts the transaction like a fresh start.
// - Bytes are eight bits, most significant first, any count per transfer.
// - Ninth clock is the acknowledge slot; low means acknowledge.
// - Not-acknowledge only for a device address mismatch.
// - Master acknowledge on a read byte makes the device release the line.
// - Master not-acknowledge on a read byte makes the device send the next byte.
// - First byte carries a 7-bit device address compared to our own.
// - Eighth address bit: zero means read, one means write.
// - Register address byte is eight bits, registers 0 to 255.
// - Register address advances after each written word or when a read goes on to a further word, and wraps 255 to 0.
// - Register values are 16 bits, upper byte first.
// - Frequency starts moving 22 us after update, settles after 30 us.
// - Pull word applies only when the upper control word is written.
// - Pull word is two's complement; zero is nominal frequency.
module opi_slave #(
	parameter logic [6:0]              SLAVE_ADDR    = 7'h60,
	parameter logic [`OPI_RANGE_W-1:0] FACTORY_RANGE = 4'h0
) (
	input  wire logic                 mclk_i,
	input  wire logic                 rstn_i,
	input  wire logic                 scl_i,
	input  wire logic                 sda_i,
	output logic                      sda_o,
	output logic                      sda_oe_o,
	output opi_pkg::opi_pull_t        pull_word_o,
	output logic                      pull_update_o,
	output logic                      freq_changing_o,
	output logic                      freq_settled_o,
	output logic                      out_enable_o,
	output logic [`OPI_RANGE_W-1:0]   pull_range_o,
	output opi_pkg::opi_span_t        pull_span_o
);
	import opi_pkg::*;
	localparam logic [`OPI_CNT_W-1:0] DELAY_CYC  = `OPI_CNT_W'(`OPI_FDELAY_NS / `OPI_MCLK_NS);
	localparam logic [`OPI_CNT_W-1:0] SETTLE_CYC = `OPI_CNT_W'(`OPI_SETTLE_NS / `OPI_MCLK_NS);

	// span of a range code in units of 0.01 ppm
	function automatic opi_span_t span_of(input logic [`OPI_RANGE_W-1:0] code);
		case (code)
			4'h0:    span_of = 19'h00271;
			4'h1:    span_of = 19'h003e8;
			4'h2:    span_of = 19'h004e2;
			4'h3:    span_of = 19'h009c4;
			4'h4:    span_of = 19'h01388;
			4'h5:    span_of = 19'h01f40;
			4'h6:    span_of = 19'h02710;
			4'h7:    span_of = 19'h030d4;
			4'h8:    span_of = 19'h03a98;
			4'h9:    span_of = 19'h04e20;
			4'ha:    span_of = 19'h09c40;
			4'hb:    span_of = 19'h0ea60;
			4'hc:    span_of = 19'h13880;
			4'hd:    span_of = 19'h1d4c0;
			4'he:    span_of = 19'h27100;
			default: span_of = 19'h4e200;
		endcase
	endfunction

	// link side: sample the data line on the rising serial clock
	logic link_bit_q, link_bit_d;
	logic link_tgl_q, link_tgl_d;
	// the data line is stable while the clock is high, so a rising edge sample is exact
	always_comb begin
		link_bit_d = sda_i;
		link_tgl_d = ~link_tgl_q;
	end

	always_ff @(posedge scl_i or negedge rstn_i) begin
		if (!rstn_i) begin
			link_bit_q <= 1'b0;
			link_tgl_q <= 1'b0;
		end else begin
			link_bit_q <= link_bit_d;
			link_tgl_q <= link_tgl_d;
		end
	end

	// system side synchronisers; third stage only for edge detection
	logic [2:0] scl_q, scl_d;
	logic [2:0] sda_q, sda_d;
	logic [2:0] tgl_q, tgl_d;
	always_comb begin
		scl_d = {scl_q[1:0], scl_i};
		sda_d = {sda_q[1:0], sda_i};
		tgl_d = {tgl_q[1:0], link_tgl_q};
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			scl_q <= 3'h7;
			sda_q <= 3'h7;
			tgl_q <= 3'h0;
		end else begin
			scl_q <= scl_d;
			sda_q <= sda_d;
			tgl_q <= tgl_d;
		end
	end

	// bus events; the sampled bit is held by the link flop for a whole clock period
	logic start_ev, stop_ev, bit_ev, scl_fall;
	assign start_ev = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
	assign stop_ev  = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
	assign bit_ev   = tgl_q[1] ^ tgl_q[2];
	assign scl_fall = scl_q[2] & ~scl_q[1];

	// protocol engine and register file
	opi_state_e                state_q, state_d;
	logic [3:0]                bitcnt_q, bitcnt_d;
	logic [7:0]                shift_q, shift_d;
	logic [7:0]                addr_q, addr_d;
	logic [7:0]                hi_q, hi_d;
	logic                      lo_q, lo_d;
	logic                      ack_q, ack_d;
	logic                      rd_done_q, rd_done_d;
	logic                      oe_q, oe_d;
	opi_word_t                 tx_q, tx_d;
	opi_word_t                 lsw_q, lsw_d;
	logic [`OPI_MSW_W-1:0]     msw_q, msw_d;
	logic                      out_en_q, out_en_d;
	logic [`OPI_RANGE_W-1:0]   range_q, range_d;
	opi_pull_t                 pull_q, pull_d;
	logic                      upd_q, upd_d;
	logic [7:0]                rx_byte, tx_sel, addr_inc;
	// register read view; unmapped numbers read zero
	function automatic opi_word_t rd_reg(input logic [7:0] a);
		case (a)
			`OPI_REG_LSW:   rd_reg = lsw_q;
			`OPI_REG_MSW:   rd_reg = {5'h00, out_en_q, msw_q};
			`OPI_REG_RANGE: rd_reg = {12'h000, range_q};
			default:        rd_reg = 16'h0000;
		endcase
	endfunction
	always_comb begin
		state_d   = state_q;
		bitcnt_d  = bitcnt_q;
		shift_d   = shift_q;
		addr_d    = addr_q;
		hi_d      = hi_q;
		lo_d      = lo_q;
		ack_d     = ack_q;
		rd_done_d = rd_done_q;
		oe_d      = oe_q;
		tx_d      = tx_q;
		lsw_d     = lsw_q;
		msw_d     = msw_q;
		out_en_d  = out_en_q;
		range_d   = range_q;
		pull_d    = pull_q;
		upd_d     = 1'b0;
		rx_byte   = {shift_q[6:0], link_bit_q};
		tx_sel    = lo_q ? tx_q[7:0] : tx_q[15:8];
		addr_inc  = addr_q + 8'h01;
		if (start_ev) begin
			state_d   = ST_ADDR;
			bitcnt_d  = 4'h0;
			ack_d     = 1'b0;
			rd_done_d = 1'b0;
			oe_d      = 1'b0;
		end else if (stop_ev) begin
			state_d  = ST_IDLE;
			bitcnt_d = 4'h0;
			ack_d    = 1'b0;
			oe_d     = 1'b0;
		end else if (bit_ev && state_q != ST_IDLE) begin
			if (bitcnt_q == `OPI_ACK_SLOT) begin
				bitcnt_d = 4'h0;
				ack_d    = 1'b0;
				// a read data byte closes with the master's answer
				if (state_q == ST_RD && !ack_q && !rd_done_q) begin
					if (!link_bit_q) begin
						rd_done_d = 1'b1;
					end else if (!lo_q) begin
						lo_d = 1'b1;
					end else begin
						lo_d   = 1'b0;
						addr_d = addr_inc;
						tx_d   = rd_reg(addr_inc);
					end
				end
			end else begin
				shift_d  = rx_byte;
				bitcnt_d = bitcnt_q + 4'h1;
				if (bitcnt_q == `OPI_LAST_BIT) begin
					case (state_q)
						ST_ADDR: begin
							if (rx_byte[7:1] == SLAVE_ADDR) begin
								ack_d = 1'b1;
								if (rx_byte[0] == `OPI_DIR_WRITE) begin
									state_d = ST_REG;
								end else begin
									state_d = ST_RD;
									lo_d    = 1'b0;
									tx_d    = rd_reg(addr_q);
								end
							end else begin
								state_d = ST_IDLE;
							end
						end
						ST_REG: begin
							addr_d  = rx_byte;
							lo_d    = 1'b0;
							ack_d   = 1'b1;
							state_d = ST_WR;
						end
						ST_WR: begin
							ack_d = 1'b1;
							if (!lo_q) begin
								hi_d = rx_byte;
								lo_d = 1'b1;
							end else begin
								lo_d   = 1'b0;
								addr_d = addr_inc;
								case (addr_q)
									`OPI_REG_LSW: lsw_d = {hi_q, rx_byte};
									`OPI_REG_MSW: begin
										msw_d    = {hi_q[1:0], rx_byte};
										out_en_d = hi_q[`OPI_OE_BIT-8];
										pull_d   = {hi_q[1:0], rx_byte, lsw_q};
										upd_d    = 1'b1;
									end
									`OPI_REG_RANGE: range_d = rx_byte[`OPI_RANGE_W-1:0];
									default: ;
								endcase
							end
						end
						default: ;
					endcase
				end
			end
		end else if (scl_fall && state_q != ST_IDLE) begin
			// the line only ever moves while the clock is low
			if (bitcnt_q == `OPI_ACK_SLOT) begin
				oe_d = ack_q;
			end else if (state_q == ST_RD && !ack_q && !rd_done_q) begin
				oe_d = ~tx_sel[~bitcnt_q[2:0]];
			end else begin
				oe_d = 1'b0;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_q   <= ST_IDLE;
			bitcnt_q  <= 4'h0;
			shift_q   <= 8'h00;
			addr_q    <= 8'h00;
			hi_q      <= 8'h00;
			lo_q      <= 1'b0;
			ack_q     <= 1'b0;
			rd_done_q <= 1'b0;
			oe_q      <= 1'b0;
			tx_q      <= 16'h0000;
			lsw_q     <= 16'h0000;
			msw_q     <= 10'h000;
			out_en_q  <= 1'b0;
			range_q   <= FACTORY_RANGE;
			pull_q    <= 26'h0000000;
			upd_q     <= 1'b0;
		end else begin
			state_q   <= state_d;
			bitcnt_q  <= bitcnt_d;
			shift_q   <= shift_d;
			addr_q    <= addr_d;
			hi_q      <= hi_d;
			lo_q      <= lo_d;
			ack_q     <= ack_d;
			rd_done_q <= rd_done_d;
			oe_q      <= oe_d;
			tx_q      <= tx_d;
			lsw_q     <= lsw_d;
			msw_q     <= msw_d;
			out_en_q  <= out_en_d;
			range_q   <= range_d;
			pull_q    <= pull_d;
			upd_q     <= upd_d;
		end
	end

	// frequency change timing: typical figures, restarted by every new word
	logic [`OPI_CNT_W-1:0] cnt_q, cnt_d;
	logic                  busy_q, busy_d;
	logic                  chg_q, chg_d;

	always_comb begin
		cnt_d  = cnt_q;
		busy_d = busy_q;
		if (upd_q) begin
			cnt_d  = '0;
			busy_d = 1'b1;
		end else if (busy_q) begin
			cnt_d = cnt_q + `OPI_CNT_W'(1);
			if (cnt_q == SETTLE_CYC - `OPI_CNT_W'(1)) begin
				busy_d = 1'b0;
			end
		end
		chg_d = busy_d && cnt_d >= DELAY_CYC;
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_q  <= '0;
			busy_q <= 1'b0;
			chg_q  <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			busy_q <= busy_d;
			chg_q  <= chg_d;
		end
	end

	// open-drain data line; serial clock is input only
	assign sda_o           = 1'b0;
	assign sda_oe_o        = oe_q;
	assign pull_word_o     = pull_q;
	assign pull_update_o   = upd_q;
	assign freq_changing_o = chg_q;
	assign freq_settled_o  = ~busy_q;
	assign out_enable_o    = out_en_q;
	assign pull_range_o    = range_q;
	assign pull_span_o     = span_of(range_q);

endmodule

// File: verification/opi_slave_sva.sv
`timescale 1ns/1ps
`include "opi_defs.svh"
module opi_slave_sva #(
	parameter logic [6:0]              SLAVE_ADDR    = 7'h60,
	parameter logic [`OPI_RANGE_W-1:0] FACTORY_RANGE = 4'h0
) (
	input wire logic                      mclk_i,
	input wire logic                      rstn_i,
	input wire logic                      scl_i,
	input wire logic                      sda_i,
	input wire logic                      sda_o,
	input wire logic                      sda_oe_o,
	input wire opi_pkg::opi_pull_t        pull_word_o,
	input wire logic                      pull_update_o,
	input wire logic                      freq_changing_o,
	input wire logic                      freq_settled_o,
	input wire logic                      out_enable_o,
	input wire logic [`OPI_RANGE_W-1:0]   pull_range_o,
	input wire opi_pkg::opi_span_t        pull_span_o
);
	import opi_pkg::*;
	// span per code, 0.01 ppm units
	localparam opi_span_t SPAN [16] = '{19'h00271, 19'h003e8, 19'h004e2, 19'h009c4, 19'h01388, 19'h01f40,
		19'h02710, 19'h030d4, 19'h03a98, 19'h04e20, 19'h09c40, 19'h0ea60, 19'h13880, 19'h1d4c0,
		19'h27100, 19'h4e200};
	logic [11:0] age_q;
	logic [11:0] age_d;

	// cycles since last update; 0 means none, saturates so it never wraps
	always_comb begin
		age_d = age_q;
		if (pull_update_o)
			age_d = 12'h001;
		else if (age_q != 12'h000 && age_q != 12'hfff)
			age_d = age_q + 12'h001;
	end
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i)
			age_q <= 12'h000;
		else
			age_q <= age_d;
	end

	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);

	sequence s_start;
		scl_i && $past(scl_i) && $fell(sda_i);
	endsequence
	sequence s_quiet;
		!sda_oe_o [*8];
	endsequence

	// margins of ten cycles around the edges cover the sync latency
	chk_sda_never_high: assert property (sda_o == 1'b0)
		else $error("data line driven high");
	chk_oe_steady_high: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
		else $error("data drive changed while clock high");
	chk_start_quiet: assert property (s_start |=> s_quiet)
		else $error("data driven right after start");
	chk_update_pulse: assert property (pull_update_o |=> !pull_update_o)
		else $error("update pulse longer than one cycle");
	chk_word_held: assert property (!pull_update_o |-> $stable(pull_word_o))
		else $error("pull word moved without update");
	chk_span_map: assert property (pull_span_o == SPAN[pull_range_o])
		else $error("span does not match range code");
	chk_reset_values: assert property ($rose(rstn_i) |-> pull_range_o == FACTORY_RANGE && pull_word_o == '0 && !out_enable_o && freq_settled_o)
		else $error("wrong values after reset");
	chk_settle_busy: assert property (age_q >= 12'h00a && age_q <= 12'hbae |-> !freq_settled_o)
		else $error("settled too early");
	chk_settle_done: assert property (!pull_update_o && (age_q == 12'h000 || age_q >= 12'hbc2) |-> freq_settled_o && !freq_changing_o)
		else $error("not settled in time");
	chk_change_delay: assert property (age_q inside {[12'h00a:12'h88e], [12'h8a2:12'hbae]} |-> freq_changing_o == (age_q > 12'h898))
		else $error("change window wrong");
endmodule

bind opi_slave opi_slave_sva #(.SLAVE_ADDR(SLAVE_ADDR), .FACTORY_RANGE(FACTORY_RANGE)) i_opi_slave_sva (.*);

// File: verification/opi_master_model.sv
`timescale 1ns/1ps
module opi_master_model #(
	parameter int HALF = 500
) (
	output logic     scl_o,
	output logic     sda_low_o,
	input wire logic sda_i
);
	localparam int QTR = HALF / 2;

	// idle: clock high, data released
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end

	// start or repeated start: data falls with clock high
	task automatic start_cond();
		sda_low_o = 1'b0;
		#QTR scl_o = 1'b1;
		#HALF sda_low_o = 1'b1;
		#HALF scl_o = 1'b0;
		#QTR;
	endtask

	// stop: data rises with clock high, clock then stands high
	task automatic stop_cond();
		sda_low_o = 1'b1;
		#QTR scl_o = 1'b1;
		#HALF sda_low_o = 1'b0;
		#HALF;
	endtask

	// nine clocks msb first; a one in tx releases the line
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			sda_low_o = ~tx[i];
			#QTR scl_o = 1'b1;
			#HALF rx[i] = sda_i;
			scl_o = 1'b0;
			#QTR;
		end
	endtask
endmodule

// File: verification/tb_opi_slave.sv
`timescale 1ns/1ps
`include "opi_defs.svh"
module tb_opi_slave;
	import opi_pkg::*;
	// nonzero factory code so the reset value shows
	localparam logic [3:0] FR = 4'h5;
	localparam logic [39:0] ROWS [3] = '{40'h00_1234_1234, 40'h01_ffff_07ff, 40'h02_fff3_0003};
	logic      mclk_i = 1'b0;
	logic      rstn_i = 1'b0;
	logic      scl, m_low, sda_o, sda_oe_o, upd, chg, setl, oe;
	opi_pull_t pw;
	logic [3:0] rng;
	logic [8:0] rx;
	logic [15:0] rdat;
	int        fails = 0;
	int        n_checks = 0;
	// pulled-up open-drain data line
	wire sda = ~((sda_oe_o & ~sda_o) | m_low);

	always #5 mclk_i = ~mclk_i;

	opi_slave #(.FACTORY_RANGE(FR)) i_opi_slave (.mclk_i(mclk_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe_o(sda_oe_o), .pull_word_o(pw), .pull_update_o(upd), .freq_changing_o(chg),
		.freq_settled_o(setl), .out_enable_o(oe), .pull_range_o(rng), .pull_span_o());
	opi_master_model i_opi_master_model (.scl_o(scl), .sda_low_o(m_low), .sda_i(sda));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("checks=%0d fails=%0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// one byte out, then compare the acknowledge slot
	task automatic put(input logic [7:0] b, input logic nak);
		i_opi_master_model.xfer({b, 1'b1}, rx);
		check(32'(rx[0]), 32'(nak));
	endtask

	task automatic wr(input logic [7:0] r, input logic [15:0] d);
		i_opi_master_model.start_cond();
		put(8'hc1, 1'b0);
		put(r, 1'b0);
		put(d[15:8], 1'b0);
		put(d[7:0], 1'b0);
		i_opi_master_model.stop_cond();
	endtask

	// hi byte refused so the device goes on, lo byte acked so it lets go
	task automatic rd(input logic [7:0] r, output logic [15:0] d);
		i_opi_master_model.start_cond();
		put(8'hc1, 1'b0);
		put(r, 1'b0);
		i_opi_master_model.start_cond();
		put(8'hc0, 1'b0);
		i_opi_master_model.xfer(9'h1ff, rx);
		d[15:8] = rx[8:1];
		i_opi_master_model.xfer(9'h1fe, rx);
		d[7:0] = rx[8:1];
		i_opi_master_model.xfer(9'h1ff, rx);
		check(32'(rx[8:1]), 32'h0ff);
		i_opi_master_model.stop_cond();
	endtask

	// hang guard
	initial begin
		repeat (100000) @(posedge mclk_i);
		fails++;
		complete_run();
	end

	initial begin
		repeat (20) @(posedge mclk_i);
		rstn_i <= 1'b1;
		@(posedge mclk_i);
		#1;
		check(32'(rng), 32'(FR));
		check(32'(pw), 32'h0);
		repeat (3) @(posedge mclk_i);
		// bus edges then stay clear of the system clock edge
		#2;
		for (int k = 0; k < 3; k++) begin
			wr(ROWS[k][39:32], ROWS[k][31:16]);
			rd(ROWS[k][39:32], rdat);
			check(32'(rdat), 32'(ROWS[k][15:0]));
		end
		check(32'(pw), 32'h3ff1234);
		check(32'(oe), 32'h1);
		// three words from 255: first dropped, then wraps into the pull word
		i_opi_master_model.start_cond();
		put(8'hc1, 1'b0);
		put(8'hff, 1'b0);
		foreach (ROWS[k]) begin
			put(8'(8'h11 * k), 1'b0);
			put(8'(8'h22 * k), 1'b0);
		end
		i_opi_master_model.stop_cond();
		check(32'(pw), 32'h2441122);
		check(32'(oe), 32'h0);
		// every third code, ending on 15, keeps the run short
		for (int c = 0; c < 16; c += 3) begin
			wr(8'h02, 16'(c));
			check(32'(rng), 32'(c));
		end
		// foreign address: nothing acked, nothing taken
		i_opi_master_model.start_cond();
		put(8'hc3, 1'b1);
		put(8'h02, 1'b1);
		i_opi_master_model.stop_cond();
		check(32'(rng), 32'hf);
		@(posedge mclk_i);
		rstn_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		rstn_i <= 1'b1;
		@(posedge mclk_i);
		#1;
		check(32'(rng), 32'(FR));
		complete_run();
	end
endmodule
